/* src/csd_defines.vh */
// Purpose: shared constants of the arithmetic and shift decoder
// Assumes: included by bare name, definitions only
// Notes:   cycle templates hold one 2-bit bus kind per step, step 0 lowest
`ifndef CSD_DEFINES_VH
`define CSD_DEFINES_VH
// ****************************************
// opcodes and opcode nibbles
// ****************************************
`define CSD_OPC_PREFIX    8'h9e
`define CSD_OPC_SP_ADD    8'ha7
`define CSD_OPC_HX_ADD    8'haf
`define CSD_LO_ADC        4'h9
`define CSD_LO_ADD        4'hb
`define CSD_LO_AND        4'h4
`define CSD_LO_SHL        4'h8
`define CSD_LO_SHR        4'h7
`define CSD_HI_IMM        4'ha
`define CSD_HI_DIR        4'hb
`define CSD_HI_EXT        4'hc
`define CSD_HI_IX2        4'hd
`define CSD_HI_IX1        4'he
`define CSD_HI_IX         4'hf
`define CSD_HI_SH_DIR     4'h3
`define CSD_HI_SH_ACC     4'h4
`define CSD_HI_SH_XLO     4'h5
`define CSD_HI_SH_IX1     4'h6
`define CSD_HI_SH_IX      4'h7
// ****************************************
// addressing modes and operation classes
// ****************************************
`define CSD_M_IMM         4'h0
`define CSD_M_DIR         4'h1
`define CSD_M_EXT         4'h2
`define CSD_M_IX2         4'h3
`define CSD_M_IX1         4'h4
`define CSD_M_IX          4'h5
`define CSD_M_SP2         4'h6
`define CSD_M_SP1         4'h7
`define CSD_M_INH         4'h8
`define CSD_C_NOP         3'h0
`define CSD_C_ADC         3'h1
`define CSD_C_ADD         3'h2
`define CSD_C_AND         3'h3
`define CSD_C_SHL         3'h4
`define CSD_C_SHR         3'h5
`define CSD_C_SPI         3'h6
`define CSD_C_HXI         3'h7
// ****************************************
// bus cycle kinds and cycle templates
// ****************************************
`define CSD_K_P           2'h0
`define CSD_K_R           2'h1
`define CSD_K_F           2'h2
`define CSD_K_W           2'h3
`define CSD_TPL_PP        12'h000
`define CSD_TPL_RPP       12'h001
`define CSD_TPL_PRPP      12'h004
`define CSD_TPL_RFP       12'h009
`define CSD_TPL_PPRPP     12'h010
`define CSD_TPL_RFW       12'h039
`define CSD_TPL_PRFWPP    12'h0e4
`define CSD_LEN_IMM       3'h2
`define CSD_LEN_DIR       3'h3
`define CSD_LEN_EXT       3'h4
`define CSD_LEN_IX2       3'h4
`define CSD_LEN_IX1       3'h3
`define CSD_LEN_IX        3'h3
`define CSD_LEN_SP2       3'h5
`define CSD_LEN_SP1       3'h4
`define CSD_LEN_SH_DIR    3'h5
`define CSD_LEN_SH_INH    3'h1
`define CSD_LEN_SH_IX1    3'h5
`define CSD_LEN_SH_IX     3'h4
`define CSD_LEN_SH_SP1    3'h6
`define CSD_LEN_NOP       3'h1
// ****************************************
// register port map and reset values
// ****************************************
`define CSD_REG_CTRL      4'h0
`define CSD_REG_ACC       4'h1
`define CSD_REG_IDX_HI    4'h2
`define CSD_REG_IDX_LO    4'h3
`define CSD_REG_SP_HI     4'h4
`define CSD_REG_SP_LO     4'h5
`define CSD_REG_FLAGS     4'h6
`define CSD_REG_FP_HI     4'h7
`define CSD_REG_FP_LO     4'h8
`define CSD_RST_FLAGS     8'h68
`define CSD_RST_SP        16'h00ff
`define CSD_RST_FP        16'h0000
`define CSD_FLAGS_ONES    8'h60
`define CSD_F_V           7
`define CSD_F_H           4
`define CSD_F_N           2
`define CSD_F_Z           1
`define CSD_F_C           0
`endif

/* src/csd_alu.v */
// Purpose: 8-bit arithmetic, logic and shift unit with flag update
// Assumes: purely combinational, fed by the sequencer
// Notes:   flags not named by the class pass through untouched
`include "csd_defines.vh"
module csd_alu (
  input  wire [2:0] i_cls,
  input  wire [7:0] i_a,
  input  wire [7:0] i_m,
  input  wire [7:0] i_flags,
  output reg  [7:0] o_res,
  output reg  [7:0] o_flags
);
  reg [8:0] sum;
  always @* begin
    sum     = 9'h000;
    o_res   = i_a;
    o_flags = i_flags;
    case (i_cls)
      `CSD_C_ADC, `CSD_C_ADD: begin
        sum = {1'b0, i_a} + {1'b0, i_m}
            + {8'h00, (i_cls == `CSD_C_ADC) & i_flags[`CSD_F_C]};
        o_res = sum[7:0];
        o_flags[`CSD_F_H] = i_a[4] ^ i_m[4] ^ sum[4];
        o_flags[`CSD_F_C] = sum[8];
        o_flags[`CSD_F_V] = (i_a[7] & i_m[7] & ~sum[7])
                          | (~i_a[7] & ~i_m[7] & sum[7]);
      end
      `CSD_C_AND: begin
        o_res = i_a & i_m;
        o_flags[`CSD_F_V] = 1'b0;
      end
      `CSD_C_SHL: begin
        o_res = {i_m[6:0], 1'b0};
        o_flags[`CSD_F_C] = i_m[7];
        o_flags[`CSD_F_V] = i_m[6] ^ i_m[7];
      end
      `CSD_C_SHR: begin
        o_res = {i_m[7], i_m[7:1]};
        o_flags[`CSD_F_C] = i_m[0];
        o_flags[`CSD_F_V] = i_m[7] ^ i_m[0];
      end
      default: begin
        o_res = i_a;
      end
    endcase
    if (i_cls != `CSD_C_NOP && i_cls != `CSD_C_SPI && i_cls != `CSD_C_HXI) begin
      o_flags[`CSD_F_N] = o_res[7];
      o_flags[`CSD_F_Z] = (o_res == 8'h00);
    end
  end
endmodule // csd_alu

/* src/csd_core.v */
// Purpose: decoder and sequencer for add, and, signed-add and shift opcodes
// Assumes: program/data memory answers a read in the same cycle
// Notes:   one bus cycle per clock; registers other than control writable only while halted
//
// Summary of operation
// - add with carry on opcodes a9..f9, stack forms 9e d9/e9
// - add without carry on opcodes ab..fb, stack forms 9e db/eb
// - a7 adds signed immediate to stack pointer, 2 cycles, flags kept
// - af adds signed immediate to index pair, 2 cycles, flags kept
// - and on opcodes a4..f4, stack forms 9e d4/e4
// - and stores a and m, clears overflow, sets negative and zero
// - left shift opcodes 38, 48, 58, 68, 78 and 9e 68
// - left shift takes 5, 1, 1, 5, 4 and 6 cycles by mode
// - right shift opcodes 37..77 and 9e 67, same cycle counts
// - each cycle is a fetch, read, write or free bus cycle
// - add with carry takes 2 immediate, 3 direct, 4 extended cycles
// - half-carry follows carry from bit 3 into bit 4 on adds
// - carry follows carry out of bit 7 on adds
`include "csd_defines.vh"
module csd_core #(
  parameter [15:0] FP_RESET = `CSD_RST_FP
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire [3:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [7:0]  o_reg_rdata,
  output reg  [15:0] o_mem_addr,
  output wire        o_mem_rd,
  output wire        o_mem_wr,
  output wire [7:0]  o_mem_wdata,
  input  wire [7:0]  i_mem_rdata,
  output wire [1:0]  o_cycle_kind,
  output wire        o_insn_end
);
  // ****************************************
  // state
  // ****************************************
  reg [7:0]  acc_reg;
  reg [15:0] hx_reg;
  reg [15:0] sp_reg;
  reg [7:0]  flags_reg;
  reg [15:0] fp_reg;
  reg [7:0]  q0_reg;
  reg [7:0]  q1_reg;
  reg        fill_cnt_reg;
  reg        filled_reg;
  reg        run_reg;
  reg [2:0]  step_reg;
  reg [2:0]  cls_reg;
  reg [3:0]  mode_reg;
  reg        xsel_reg;
  reg [11:0] tpl_reg;
  reg [2:0]  len_reg;
  reg [7:0]  m_reg;

  // ****************************************
  // opcode decode from the instruction queue
  // ****************************************
  reg        pre;
  reg [7:0]  opc;
  reg [2:0]  d_cls;
  reg [3:0]  d_mode;
  reg        d_xsel;
  always @* begin
    pre    = (q0_reg == `CSD_OPC_PREFIX);
    opc    = pre ? q1_reg : q0_reg;
    d_cls  = `CSD_C_NOP;
    d_mode = `CSD_M_INH;
    d_xsel = 1'b0;
    if (!pre && opc == `CSD_OPC_SP_ADD) begin
      d_cls  = `CSD_C_SPI;
      d_mode = `CSD_M_IMM;
    end else if (!pre && opc == `CSD_OPC_HX_ADD) begin
      d_cls  = `CSD_C_HXI;
      d_mode = `CSD_M_IMM;
    end else if ((opc[3:0] == `CSD_LO_ADC || opc[3:0] == `CSD_LO_ADD ||
                  opc[3:0] == `CSD_LO_AND) && opc[7:4] >= `CSD_HI_IMM) begin
      if (opc[3:0] == `CSD_LO_ADC) begin
        d_cls = `CSD_C_ADC;
      end else if (opc[3:0] == `CSD_LO_ADD) begin
        d_cls = `CSD_C_ADD;
      end else begin
        d_cls = `CSD_C_AND;
      end
      if (pre) begin
        if (opc[7:4] == `CSD_HI_IX2) begin
          d_mode = `CSD_M_SP2;
        end else if (opc[7:4] == `CSD_HI_IX1) begin
          d_mode = `CSD_M_SP1;
        end else begin
          d_cls = `CSD_C_NOP;
        end
      end else begin
        case (opc[7:4])
          `CSD_HI_IMM: d_mode = `CSD_M_IMM;
          `CSD_HI_DIR: d_mode = `CSD_M_DIR;
          `CSD_HI_EXT: d_mode = `CSD_M_EXT;
          `CSD_HI_IX2: d_mode = `CSD_M_IX2;
          `CSD_HI_IX1: d_mode = `CSD_M_IX1;
          default:     d_mode = `CSD_M_IX;
        endcase
      end
    end else if ((opc[3:0] == `CSD_LO_SHL || opc[3:0] == `CSD_LO_SHR) &&
                 opc[7:4] >= `CSD_HI_SH_DIR && opc[7:4] <= `CSD_HI_SH_IX) begin
      d_cls = (opc[3:0] == `CSD_LO_SHL) ? `CSD_C_SHL : `CSD_C_SHR;
      if (pre) begin
        if (opc[7:4] == `CSD_HI_SH_IX1) begin
          d_mode = `CSD_M_SP1;
        end else begin
          d_cls = `CSD_C_NOP;
        end
      end else begin
        case (opc[7:4])
          `CSD_HI_SH_DIR: d_mode = `CSD_M_DIR;
          `CSD_HI_SH_ACC: d_mode = `CSD_M_INH;
          `CSD_HI_SH_XLO: begin
            d_mode = `CSD_M_INH;
            d_xsel = 1'b1;
          end
          `CSD_HI_SH_IX1: d_mode = `CSD_M_IX1;
          default:        d_mode = `CSD_M_IX;
        endcase
      end
    end
  end

  // ****************************************
  // cycle template per class and mode
  // ****************************************
  reg [11:0] d_tpl;
  reg [2:0]  d_len;
  wire       d_rmw = (d_cls == `CSD_C_SHL) || (d_cls == `CSD_C_SHR);
  always @* begin
    d_tpl = `CSD_TPL_PP;
    d_len = `CSD_LEN_NOP;
    if (d_cls == `CSD_C_NOP) begin
      d_len = `CSD_LEN_NOP;
    end else if (d_rmw) begin
      case (d_mode)
        `CSD_M_DIR: begin
          d_tpl = `CSD_TPL_RFW;
          d_len = `CSD_LEN_SH_DIR;
        end
        `CSD_M_IX1: begin
          d_tpl = `CSD_TPL_RFW;
          d_len = `CSD_LEN_SH_IX1;
        end
        `CSD_M_IX: begin
          d_tpl = `CSD_TPL_RFW;
          d_len = `CSD_LEN_SH_IX;
        end
        `CSD_M_SP1: begin
          d_tpl = `CSD_TPL_PRFWPP;
          d_len = `CSD_LEN_SH_SP1;
        end
        default: begin
          d_tpl = `CSD_TPL_PP;
          d_len = `CSD_LEN_SH_INH;
        end
      endcase
    end else begin
      case (d_mode)
        `CSD_M_DIR: begin
          d_tpl = `CSD_TPL_RPP;
          d_len = `CSD_LEN_DIR;
        end
        `CSD_M_EXT: begin
          d_tpl = `CSD_TPL_PRPP;
          d_len = `CSD_LEN_EXT;
        end
        `CSD_M_IX2: begin
          d_tpl = `CSD_TPL_PRPP;
          d_len = `CSD_LEN_IX2;
        end
        `CSD_M_IX1: begin
          d_tpl = `CSD_TPL_RPP;
          d_len = `CSD_LEN_IX1;
        end
        `CSD_M_IX: begin
          d_tpl = `CSD_TPL_RFP;
          d_len = `CSD_LEN_IX;
        end
        `CSD_M_SP2: begin
          d_tpl = `CSD_TPL_PPRPP;
          d_len = `CSD_LEN_SP2;
        end
        `CSD_M_SP1: begin
          d_tpl = `CSD_TPL_PRPP;
          d_len = `CSD_LEN_SP1;
        end
        default: begin
          d_tpl = `CSD_TPL_PP;
          d_len = `CSD_LEN_IMM;
        end
      endcase
    end
  end

  // ****************************************
  // current step and bus cycle
  // ****************************************
  // step 0 decodes live from the queue; later steps use the latched copy,
  // since operand fetches shift the queue under the decoder
  wire        first  = (step_reg == 3'h0);
  wire [2:0]  c_cls  = first ? d_cls  : cls_reg;
  wire [3:0]  c_mode = first ? d_mode : mode_reg;
  wire        c_xsel = first ? d_xsel : xsel_reg;
  wire [11:0] c_tpl  = first ? d_tpl  : tpl_reg;
  wire [2:0]  c_len  = first ? d_len  : len_reg;
  wire        go     = filled_reg && (run_reg || !first);
  wire [1:0]  kind   = c_tpl[{step_reg, 1'b0} +: 2];
  wire        last   = go && (step_reg == c_len - 3'h1);
  wire        fetch  = !filled_reg || (go && kind == `CSD_K_P);
  wire        hold   = first && !run_reg;

  reg [15:0] ea;
  always @* begin
    case (c_mode)
      `CSD_M_DIR: ea = {8'h00, q1_reg};
      `CSD_M_EXT: ea = {q0_reg, q1_reg};
      `CSD_M_IX2: ea = hx_reg + {q0_reg, q1_reg};
      `CSD_M_IX1: ea = hx_reg + {8'h00, q1_reg};
      `CSD_M_IX:  ea = hx_reg;
      `CSD_M_SP2: ea = sp_reg + {q0_reg, q1_reg};
      `CSD_M_SP1: ea = sp_reg + {8'h00, q1_reg};
      default:    ea = fp_reg;
    endcase
    o_mem_addr = fetch ? fp_reg : ea;
  end

  assign o_mem_rd     = fetch || (go && kind == `CSD_K_R);
  assign o_mem_wr     = go && kind == `CSD_K_W;
  assign o_cycle_kind = fetch ? `CSD_K_P : (go ? kind : `CSD_K_F);
  assign o_insn_end   = last;

  // ****************************************
  // arithmetic unit
  // ****************************************
  wire [7:0] alu_m = (c_mode == `CSD_M_INH) ? (c_xsel ? hx_reg[7:0] : acc_reg)
                                            : m_reg;
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  csd_alu u_alu (
    .i_cls   (c_cls),
    .i_a     (acc_reg),
    .i_m     (alu_m),
    .i_flags (flags_reg),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );
  assign o_mem_wdata = alu_res;
  wire [15:0] imm_sx = {{8{m_reg[7]}}, m_reg};
  wire        reg_ok = i_reg_wr && hold;

  // ****************************************
  // sequencer and registers
  // ****************************************
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_reg      <= 8'h00;
      hx_reg       <= 16'h0000;
      sp_reg       <= `CSD_RST_SP;
      flags_reg    <= `CSD_RST_FLAGS;
      fp_reg       <= FP_RESET;
      q0_reg       <= 8'h00;
      q1_reg       <= 8'h00;
      fill_cnt_reg <= 1'b0;
      filled_reg   <= 1'b0;
      run_reg      <= 1'b0;
      step_reg     <= 3'h0;
      cls_reg      <= `CSD_C_NOP;
      mode_reg     <= `CSD_M_INH;
      xsel_reg     <= 1'b0;
      tpl_reg      <= `CSD_TPL_PP;
      len_reg      <= `CSD_LEN_NOP;
      m_reg        <= 8'h00;
      o_reg_rdata  <= 8'h00;
    end else begin
      if (fetch) begin
        fp_reg <= fp_reg + 16'h0001;
        q0_reg <= q1_reg;
        q1_reg <= i_mem_rdata;
        if (!filled_reg) begin
          fill_cnt_reg <= 1'b1;
          filled_reg   <= fill_cnt_reg;
        end
      end
      if (go) begin
        step_reg <= last ? 3'h0 : step_reg + 3'h1;
        if (first) begin
          cls_reg  <= d_cls;
          mode_reg <= d_mode;
          xsel_reg <= d_xsel;
          tpl_reg  <= d_tpl;
          len_reg  <= d_len;
          m_reg    <= q1_reg;
        end
        if (kind == `CSD_K_R) begin
          m_reg <= i_mem_rdata;
        end
        if (kind == `CSD_K_W) begin
          flags_reg <= alu_flags | `CSD_FLAGS_ONES;
        end
      end
      if (last) begin
        case (c_cls)
          `CSD_C_ADC, `CSD_C_ADD, `CSD_C_AND: begin
            acc_reg   <= alu_res;
            flags_reg <= alu_flags | `CSD_FLAGS_ONES;
          end
          `CSD_C_SPI: sp_reg <= sp_reg + imm_sx;
          `CSD_C_HXI: hx_reg <= hx_reg + imm_sx;
          `CSD_C_SHL, `CSD_C_SHR: begin
            if (c_mode == `CSD_M_INH) begin
              if (c_xsel) begin
                hx_reg[7:0] <= alu_res;
              end else begin
                acc_reg <= alu_res;
              end
              flags_reg <= alu_flags | `CSD_FLAGS_ONES;
            end
          end
          default: begin
          end
        endcase
      end
      // register port writes other than control only land while halted between instructions,
      // so they never race the sequencer
      if (i_reg_wr && i_reg_addr == `CSD_REG_CTRL) begin
        run_reg <= i_reg_wdata[0];
      end
      if (reg_ok) begin
        if (i_reg_addr == `CSD_REG_ACC) begin
          acc_reg <= i_reg_wdata;
        end else if (i_reg_addr == `CSD_REG_IDX_HI) begin
          hx_reg[15:8] <= i_reg_wdata;
        end else if (i_reg_addr == `CSD_REG_IDX_LO) begin
          hx_reg[7:0] <= i_reg_wdata;
        end else if (i_reg_addr == `CSD_REG_SP_HI) begin
          sp_reg[15:8] <= i_reg_wdata;
        end else if (i_reg_addr == `CSD_REG_SP_LO) begin
          sp_reg[7:0] <= i_reg_wdata;
        end else if (i_reg_addr == `CSD_REG_FLAGS) begin
          flags_reg <= i_reg_wdata | `CSD_FLAGS_ONES;
        end else if (i_reg_addr == `CSD_REG_FP_HI) begin
          fp_reg[15:8] <= i_reg_wdata;
          fill_cnt_reg <= 1'b0;
          filled_reg   <= 1'b0;
        end else if (i_reg_addr == `CSD_REG_FP_LO) begin
          fp_reg[7:0]  <= i_reg_wdata;
          fill_cnt_reg <= 1'b0;
          filled_reg   <= 1'b0;
        end
      end
      if (i_reg_rd) begin
        if (i_reg_addr == `CSD_REG_CTRL) begin
          o_reg_rdata <= {5'h00, filled_reg, !first, run_reg};
        end else if (i_reg_addr == `CSD_REG_ACC) begin
          o_reg_rdata <= acc_reg;
        end else if (i_reg_addr == `CSD_REG_IDX_HI) begin
          o_reg_rdata <= hx_reg[15:8];
        end else if (i_reg_addr == `CSD_REG_IDX_LO) begin
          o_reg_rdata <= hx_reg[7:0];
        end else if (i_reg_addr == `CSD_REG_SP_HI) begin
          o_reg_rdata <= sp_reg[15:8];
        end else if (i_reg_addr == `CSD_REG_SP_LO) begin
          o_reg_rdata <= sp_reg[7:0];
        end else if (i_reg_addr == `CSD_REG_FLAGS) begin
          o_reg_rdata <= flags_reg;
        end else if (i_reg_addr == `CSD_REG_FP_HI) begin
          o_reg_rdata <= fp_reg[15:8];
        end else if (i_reg_addr == `CSD_REG_FP_LO) begin
          o_reg_rdata <= fp_reg[7:0];
        end else begin
          o_reg_rdata <= 8'h00;
        end
      end
    end
  end
endmodule // csd_core

/* bench/csd_chk.sv */
// Purpose: bus-cycle checks on the core's memory port
// Assumes: one clock, asynchronous active-low reset
// Notes:   rd_q keeps the last data byte read, for the shift write-back
module csd_chk (
  input wire        i_clk,
  input wire        i_reset_n,
  input wire [15:0] o_mem_addr,
  input wire        o_mem_rd,
  input wire        o_mem_wr,
  input wire [7:0]  o_mem_wdata,
  input wire [7:0]  i_mem_rdata,
  input wire [1:0]  o_cycle_kind,
  input wire        o_insn_end
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] rd_q;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_q <= 8'h00;
    end else if (o_cycle_kind == 2'h1) begin
      rd_q <= i_mem_rdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ********
  // cycle kinds
  // ********
  read_kind_a: assert property ((o_cycle_kind <= 2'h1) == o_mem_rd)
    else $error("read strobe does not match cycle kind");
  write_kind_a: assert property ((o_cycle_kind == 2'h3) == o_mem_wr)
    else $error("write strobe does not match cycle kind");
  end_on_fetch_a: assert property (o_insn_end |-> o_cycle_kind == 2'h0)
    else $error("instruction ends off a fetch");
  free_next_a: assert property (o_cycle_kind == 2'h1 ##1 o_cycle_kind == 2'h2
    |=> o_cycle_kind == 2'h0 || o_cycle_kind == 2'h3)
    else $error("free cycle not followed by fetch or write");
  // ********
  // read-modify-write of shifts
  // ********
  rmw_order_a: assert property (o_mem_wr |-> $past(o_cycle_kind) == 2'h2
    && $past(o_cycle_kind, 2) == 2'h1)
    else $error("write not preceded by read and free");
  rmw_addr_a: assert property (o_mem_wr |-> o_mem_addr == $past(o_mem_addr, 2))
    else $error("write address differs from read address");
  rmw_tail_a: assert property (o_mem_wr |=> o_cycle_kind == 2'h0)
    else $error("write not followed by fetch");
  shift_data_a: assert property (o_mem_wr |-> o_mem_wdata == {rd_q[6:0], 1'b0}
    || o_mem_wdata == {rd_q[7], rd_q[7:1]})
    else $error("written byte is not a shift of the read byte");
endmodule // csd_chk

bind csd_core csd_chk i_csd_chk (
  .i_clk        (i_clk),
  .i_reset_n    (i_reset_n),
  .o_mem_addr   (o_mem_addr),
  .o_mem_rd     (o_mem_rd),
  .o_mem_wr     (o_mem_wr),
  .o_mem_wdata  (o_mem_wdata),
  .i_mem_rdata  (i_mem_rdata),
  .o_cycle_kind (o_cycle_kind),
  .o_insn_end   (o_insn_end)
);

/* bench/csd_mem.sv */
// Purpose: program and data memory beside the core
// Assumes: read data same cycle, write at the closing edge
// Notes:   idle bus shows the inverse of the last byte read
module csd_mem (
  input  wire        i_clk,
  input  wire [15:0] i_addr,
  input  wire        i_rd,
  input  wire        i_wr,
  input  wire [7:0]  i_wdata,
  output wire [7:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // a stale byte must never pass for a fresh one
  assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
  always @(posedge i_clk) begin
    if (i_rd) begin
      last_q <= mem[i_addr];
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end
  initial begin
    for (int k = 0; k < 65536; k++) mem[k] = 8'h00;
  end
endmodule // csd_mem

/* bench/tb_csd_core.sv */
// Purpose: self-checking bench of the decoder core
// Assumes: core halted between tests, program at 0100
// Notes:   each test runs a pad byte, the instruction, then halts
`include "csd_defines.vh"
module tb_csd_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  wire  [7:0]  o_reg_rdata, o_mem_wdata, i_mem_rdata;
  wire  [15:0] o_mem_addr;
  wire         o_mem_rd, o_mem_wr, o_insn_end;
  wire  [1:0]  o_cycle_kind;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  string       cur = "";
  string       ends_q[$];
  string       kc = "prfw";
  csd_core i_csd_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .o_cycle_kind(o_cycle_kind), .o_insn_end(o_insn_end));
  csd_mem i_csd_mem (.i_clk(i_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  always #5 i_clk = ~i_clk;
  // ********
  // bus kind trace, one letter per cycle, split at instruction ends
  // ********
  always @(negedge i_clk) begin
    cur = {cur, kc.substr(o_cycle_kind, o_cycle_kind)};
    if (o_insn_end === 1'b1) begin
      ends_q.push_back(cur);
      cur = "";
    end
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      $display("Error %0t: timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ********
  // register port
  // ********
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
    @(posedge i_clk);
  endtask
  // ********
  // one instruction against the reference model
  // ********
  task automatic run_test(input int op, input int md);
    logic [7:0]  a, f, m, r, ef, o1, lo, g1, g2;
    logic [15:0] hx, sp, ea, ehx, esp;
    logic [8:0]  s;
    logic        c;
    logic [7:0]  code[$];
    string       tpl;
    int          tg;
    a = 8'($urandom);
    f = 8'($urandom) | `CSD_FLAGS_ONES;
    m = 8'($urandom);
    o1 = 8'($urandom);
    hx = {8'h03, 8'($urandom)};
    sp = {8'h05, 8'($urandom)};
    lo = op == 0 ? 8'h09 : op == 1 ? 8'h0b : op == 2 ? 8'h04 : op == 3 ? 8'h08 : 8'h07;
    tg = 2;
    if (op < 3) begin
      case (md)
        0: begin code = {8'ha0 | lo, o1}; m = o1; tg = 0; tpl = "pp"; end
        1: begin code = {8'hb0 | lo, o1}; ea = {8'h00, o1}; tpl = "rpp"; end
        2: begin code = {8'hc0 | lo, 8'h06, o1}; ea = {8'h06, o1}; tpl = "prpp"; end
        3: begin code = {8'hd0 | lo, 8'h04, o1}; ea = hx + {8'h04, o1}; tpl = "prpp"; end
        4: begin code = {8'he0 | lo, o1}; ea = hx + o1; tpl = "rpp"; end
        5: begin code = {8'hf0 | lo}; ea = hx; tpl = "rfp"; end
        6: begin code = {8'h9e, 8'hd0 | lo, 8'h04, o1}; ea = sp + {8'h04, o1}; tpl = "pprpp"; end
        default: begin code = {8'h9e, 8'he0 | lo, o1}; ea = sp + o1; tpl = "prpp"; end
      endcase
    end else if (op < 5) begin
      case (md)
        0: begin code = {8'h30 | lo, o1}; ea = {8'h00, o1}; tpl = "rfwpp"; end
        1: begin code = {8'h40 | lo}; m = a; tg = 0; tpl = "p"; end
        2: begin code = {8'h50 | lo}; m = hx[7:0]; tg = 1; tpl = "p"; end
        3: begin code = {8'h60 | lo, o1}; ea = hx + o1; tpl = "rfwpp"; end
        4: begin code = {8'h70 | lo}; ea = hx; tpl = "rfwp"; end
        default: begin code = {8'h9e, 8'h60 | lo, o1}; ea = sp + o1; tpl = "prfwpp"; end
      endcase
    end else begin
      code = {(op == 5) ? `CSD_OPC_SP_ADD : `CSD_OPC_HX_ADD, o1};
      tg = 3;
      tpl = "pp";
    end
    for (int k = 0; k < 16; k++) i_csd_mem.mem[16'h0100 + k] = 8'h00;
    foreach (code[k]) i_csd_mem.mem[16'h0101 + k] = code[k];
    if (tg == 2) i_csd_mem.mem[ea] = m;
    r = a;
    ef = f;
    esp = sp;
    ehx = hx;
    c = (op == 0) & f[0];
    s = a + m + c;
    case (op)
      0, 1: begin r = s[7:0]; ef[7] = a[7] == m[7] && r[7] != a[7]; ef[0] = s[8]; end
      2: begin r = a & m; ef[7] = 1'b0; end
      3: begin r = {m[6:0], 1'b0}; ef[0] = m[7]; end
      4: begin r = {m[7], m[7:1]}; ef[0] = m[0]; end
      5: esp = sp + {{8{o1[7]}}, o1};
      default: ehx = hx + {{8{o1[7]}}, o1};
    endcase
    if (op < 2) ef[4] = (a[3:0] + m[3:0] + c) > 15;
    if (op < 5) begin ef[2] = r[7]; ef[1] = r == 8'h00; end
    if (op == 3 || op == 4) ef[7] = ef[2] ^ ef[0];
    if (tg == 1) ehx[7:0] = r;
    reg_wr(`CSD_REG_FP_HI, 8'h01);
    reg_wr(`CSD_REG_FP_LO, 8'h00);
    reg_wr(`CSD_REG_ACC, a);
    reg_wr(`CSD_REG_IDX_HI, hx[15:8]);
    reg_wr(`CSD_REG_IDX_LO, hx[7:0]);
    reg_wr(`CSD_REG_SP_HI, sp[15:8]);
    reg_wr(`CSD_REG_SP_LO, sp[7:0]);
    reg_wr(`CSD_REG_FLAGS, f);
    cur = "";
    ends_q.delete();
    reg_wr(`CSD_REG_CTRL, 8'h01);
    for (int k = 0; k < 40 && ends_q.size() < 2; k++) @(posedge i_clk);
    reg_wr(`CSD_REG_CTRL, 8'h00);
    for (int k = 0; k < 8; k++) begin
      reg_rd(`CSD_REG_CTRL, g1);
      if (g1[1:0] == 2'b00) break;
    end
    checks_done++;
    if (ends_q.size() < 2 || ends_q[1] != tpl) begin
      errors++;
      $display("Error %0t: bus cycles of op %0d mode %0d, exp %s", $time, op, md, tpl);
    end
    reg_rd(`CSD_REG_ACC, g1);
    chk(g1, (op < 3 || tg == 0) ? r : a, "acc");
    reg_rd(`CSD_REG_FLAGS, g1);
    chk(g1, ef, "flags");
    reg_rd(`CSD_REG_IDX_HI, g1);
    reg_rd(`CSD_REG_IDX_LO, g2);
    chk({g1, g2}, ehx, "index pair");
    reg_rd(`CSD_REG_SP_HI, g1);
    reg_rd(`CSD_REG_SP_LO, g2);
    chk({g1, g2}, esp, "stack pointer");
    if (tg == 2 && op > 2) chk(i_csd_mem.mem[ea], r, "memory byte");
    $display("test op %0d mode %0d done", op, md);
  endtask
  initial begin
    logic [7:0] g;
    void'($urandom(62242));
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    reg_rd(`CSD_REG_SP_LO, g);
    chk(g, `CSD_RST_SP & 16'h00ff, "reset stack pointer");
    reg_rd(`CSD_REG_FLAGS, g);
    chk(g, `CSD_RST_FLAGS, "reset flags");
    reg_wr(4'hf, 8'h5a);
    reg_rd(4'hf, g);
    chk(g, 8'h00, "unmapped read");
    $display("test reset done");
    // every opcode and addressing mode once, random operands
    for (int op = 0; op < 7; op++) begin
      for (int md = 0; md < (op < 3 ? 8 : op < 5 ? 6 : 1); md++) run_test(op, md);
    end
    finish_test();
  end
endmodule // tb_csd_core
